// File: rt_ethernet_node_state_led.sv
`timescale 1ns/100ps
`default_nettype none

// Contract
// RQ1: Green LED stays off while inactive, switched off, starting or faulty. The code keeps a master in fallback flickering while switched off.
// RQ2: Master watches bus when inactive; timeout gives first preop, traffic blocks start.
// RQ3: Slave watches bus when inactive; timeout gives fallback, traffic gives first preop.
// RQ4: Fallback flickers green near ten hertz and runs the port as TCP/IP.
// RQ5: Master leaves fallback only through a reset of the interface.
// RQ6: Slave in fallback moves to first preop on fieldbus traffic.
// RQ7: First preop shows one green flash per second.
// RQ8: Master in first preop runs reduced cycle without cyclic traffic.
// RQ9: Slave in first preop takes configuration and moves on start-of-cycle frame.
// RQ10: Slave lights red in preop phases or armed when master failure is seen.
// RQ11: Second preop shows two green flashes per second.
// RQ12: Master in second preop runs cyclic traffic, ignoring cyclic input data.
// RQ13: Slave in second preop takes configuration; master command moves it to armed.
// RQ14: Armed state shows three green flashes per second.
// RQ15: Master when armed runs cyclic and async traffic, ignoring received process data.
// RQ16: Slave when armed sends mapped process data but does not evaluate received data.
// RQ17: Operational keeps green steady, applies mapping and evaluates cyclic data.
// RQ18: Stopped blinks green near two and a half hertz.
// RQ19: Master never enters the stopped state.
// RQ20: Slave stopped moves no data; only master commands enter or leave it. The code also drops it to inactive when switched off.
// RQ21: All flash patterns come from one free-running period counter.
// RQ22: Bus timeout is a loadable cycle count, reloaded on entry, cleared on traffic.
module rt_ethernet_node_state_led #(
  parameter int unsigned TICK_CYCLES = rt_node_pkg::TICK_CYCLES
) (
  input  wire logic                              mclk_i,
  input  wire logic                              reset_n_i,
  input  wire logic                              clk_en_i,
  input  wire logic                              role_master_i,
  input  wire logic                              node_enable_i,
  input  wire logic                              fieldbus_frame_i,
  input  wire logic                              soc_frame_i,
  input  wire logic                              master_fail_i,
  input  wire logic                              advance_i,
  input  wire logic                              cmd_ready_i,
  input  wire logic                              cmd_operate_i,
  input  wire logic                              cmd_stop_i,
  input  wire logic                              cmd_leave_stop_i,
  input  wire logic [rt_node_pkg::TIMEOUT_W-1:0] timeout_cycles_i,
  output var  logic                              led_green_o,
  output var  logic                              led_red_o,
  output var  rt_node_pkg::node_state_t          state_o,
  output var  logic                              role_master_o,
  output var  logic                              master_blocked_o,
  output var  logic                              tcpip_mode_o,
  output var  logic                              reduced_cycle_o,
  output var  logic                              cyclic_comm_o,
  output var  logic                              async_comm_o,
  output var  logic                              accept_config_o,
  output var  logic                              tx_pdo_o,
  output var  logic                              eval_rx_pdo_o,
  output var  logic                              drive_outputs_o,
  output var  logic                              provide_inputs_o
);

  rt_node_pkg::node_state_t         state_reg;
  rt_node_pkg::node_state_t         state_next;
  logic                             role_reg;
  logic                             role_next;
  logic                             blocked_reg;
  logic                             blocked_next;
  logic                             reload_reg;
  logic                             reload_next;
  logic [rt_node_pkg::TIMEOUT_W-1:0] timeout_cnt_reg;
  logic [rt_node_pkg::TIMEOUT_W-1:0] timeout_cnt_next;
  logic                             red_next;
  logic                             tcpip_next;
  logic                             reduced_next;
  logic                             cyclic_next;
  logic                             async_next;
  logic                             config_next;
  logic                             tx_pdo_next;
  logic                             eval_next;
  logic                             data_next;

  // Node state sequencer. Role is only re-sampled while inactive so that it
  // cannot change under a running communication phase.
  always_comb begin
    state_next       = state_reg;
    role_next        = role_reg;
    blocked_next     = blocked_reg;
    reload_next      = reload_reg;
    timeout_cnt_next = timeout_cnt_reg;
    unique case (state_reg)
      rt_node_pkg::ST_INACTIVE: begin
        role_next = role_master_i;
        if (!node_enable_i || reload_reg) begin
          timeout_cnt_next = timeout_cycles_i; // RQ22
          reload_next      = 1'b0;
        end else if (blocked_reg) begin
          state_next = rt_node_pkg::ST_INACTIVE; // RQ2
        end else if (fieldbus_frame_i) begin
          timeout_cnt_next = '0; // RQ22
          if (role_reg) begin
            blocked_next = 1'b1; // RQ2
          end else begin
            state_next = rt_node_pkg::ST_FIRST_PREOP_PHASE; // RQ3
          end
        end else if (timeout_cnt_reg == '0) begin
          state_next = role_reg ? rt_node_pkg::ST_FIRST_PREOP_PHASE : // RQ2
                                  rt_node_pkg::ST_PLAIN_TCPIP_FALLBACK; // RQ3
        end else begin
          timeout_cnt_next = timeout_cnt_reg - 1'b1;
        end
      end
      rt_node_pkg::ST_PLAIN_TCPIP_FALLBACK: begin
        if (!role_reg && fieldbus_frame_i) begin
          state_next = rt_node_pkg::ST_FIRST_PREOP_PHASE; // RQ6
        end
      end
      rt_node_pkg::ST_FIRST_PREOP_PHASE: begin
        if (role_reg ? advance_i : soc_frame_i) begin
          state_next = rt_node_pkg::ST_SECOND_PREOP_PHASE; // RQ9
        end
      end
      rt_node_pkg::ST_SECOND_PREOP_PHASE: begin
        if (!role_reg && cmd_stop_i) begin
          state_next = rt_node_pkg::ST_STOPPED; // RQ20
        end else if (role_reg ? advance_i : cmd_ready_i) begin
          state_next = rt_node_pkg::ST_ARMED_STATE; // RQ13
        end
      end
      rt_node_pkg::ST_ARMED_STATE: begin
        if (!role_reg && cmd_stop_i) begin
          state_next = rt_node_pkg::ST_STOPPED; // RQ20
        end else if (role_reg ? advance_i : cmd_operate_i) begin
          state_next = rt_node_pkg::ST_OPERATIONAL;
        end
      end
      rt_node_pkg::ST_OPERATIONAL: begin
        if (!role_reg && cmd_stop_i) begin
          state_next = rt_node_pkg::ST_STOPPED; // RQ20
        end
      end
      rt_node_pkg::ST_STOPPED: begin
        if (role_reg || cmd_leave_stop_i) begin
          state_next = rt_node_pkg::ST_SECOND_PREOP_PHASE; // RQ20
        end
      end
      default: begin
        state_next  = rt_node_pkg::ST_INACTIVE;
        reload_next = 1'b1;
      end
    endcase
    // Switching the interface off drops it to inactive, except a master in
    // fallback, which only a reset may release.
    if (!node_enable_i && state_reg != rt_node_pkg::ST_INACTIVE &&
        !(role_reg && state_reg == rt_node_pkg::ST_PLAIN_TCPIP_FALLBACK)) begin // RQ5
      state_next  = rt_node_pkg::ST_INACTIVE; // RQ1
      reload_next = 1'b1; // RQ22
    end
  end

  // Per-state communication permissions, decoded from the next state so the
  // registered outputs line up with the state register; the red LED is decoded from the current state and lags it by one cycle.
  always_comb begin
    tcpip_next   = (state_next == rt_node_pkg::ST_PLAIN_TCPIP_FALLBACK); // RQ4
    reduced_next = role_reg && (state_next == rt_node_pkg::ST_FIRST_PREOP_PHASE); // RQ8
    cyclic_next  = (state_next == rt_node_pkg::ST_ARMED_STATE) ||
                   (state_next == rt_node_pkg::ST_OPERATIONAL) ||
                   (role_reg && state_next == rt_node_pkg::ST_SECOND_PREOP_PHASE); // RQ12
    async_next   = (state_next == rt_node_pkg::ST_ARMED_STATE) ||
                   (state_next == rt_node_pkg::ST_OPERATIONAL); // RQ15
    config_next  = !role_reg && ((state_next == rt_node_pkg::ST_FIRST_PREOP_PHASE) ||
                                 (state_next == rt_node_pkg::ST_SECOND_PREOP_PHASE)); // RQ13
    tx_pdo_next  = (state_next == rt_node_pkg::ST_OPERATIONAL) ||
                   (!role_reg && state_next == rt_node_pkg::ST_ARMED_STATE); // RQ16
    eval_next    = (state_next == rt_node_pkg::ST_OPERATIONAL); // RQ17
    data_next    = (state_next == rt_node_pkg::ST_OPERATIONAL); // RQ20
    red_next     = !role_reg && master_fail_i &&
                   ((state_reg == rt_node_pkg::ST_FIRST_PREOP_PHASE) ||
                    (state_reg == rt_node_pkg::ST_SECOND_PREOP_PHASE) ||
                    (state_reg == rt_node_pkg::ST_ARMED_STATE)); // RQ10
  end

  // State and output registers; the clock enable freezes all of them.
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      state_reg        <= rt_node_pkg::ST_INACTIVE;
      role_reg         <= 1'b0;
      blocked_reg      <= 1'b0;
      reload_reg       <= 1'b1;
      timeout_cnt_reg  <= rt_node_pkg::TIMEOUT_RESET;
      led_red_o        <= 1'b0;
      tcpip_mode_o     <= 1'b0;
      reduced_cycle_o  <= 1'b0;
      cyclic_comm_o    <= 1'b0;
      async_comm_o     <= 1'b0;
      accept_config_o  <= 1'b0;
      tx_pdo_o         <= 1'b0;
      eval_rx_pdo_o    <= 1'b0;
      drive_outputs_o  <= 1'b0;
      provide_inputs_o <= 1'b0;
    end else if (clk_en_i) begin
      state_reg        <= state_next;
      role_reg         <= role_next;
      blocked_reg      <= blocked_next;
      reload_reg       <= reload_next;
      timeout_cnt_reg  <= timeout_cnt_next;
      led_red_o        <= red_next;
      tcpip_mode_o     <= tcpip_next;
      reduced_cycle_o  <= reduced_next;
      cyclic_comm_o    <= cyclic_next;
      async_comm_o     <= async_next;
      accept_config_o  <= config_next;
      tx_pdo_o         <= tx_pdo_next;
      eval_rx_pdo_o    <= eval_next;
      drive_outputs_o  <= data_next;
      provide_inputs_o <= data_next;
    end
  end

  assign state_o          = state_reg;
  assign role_master_o    = role_reg;
  assign master_blocked_o = blocked_reg;

  // Green pattern encoder; it lags the state register by one cycle.
  status_led_encoder #(
    .TICK_CYCLES (TICK_CYCLES)
  ) i_status_led_encoder (
    .mclk_i    (mclk_i),
    .reset_n_i (reset_n_i),
    .clk_en_i  (clk_en_i),
    .state_i   (state_reg),
    .led_o     (led_green_o)
  );

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!reset_n_i);

  // Checks on the sequencer and the indicators.
  green_off_inactive_a: assert property ( // RQ1
    clk_en_i && state_reg == rt_node_pkg::ST_INACTIVE |=> !led_green_o)
    else $error("Green LED lit while inactive.");

  master_timeout_a: assert property ( // RQ2
    clk_en_i && state_reg == rt_node_pkg::ST_INACTIVE && role_reg && node_enable_i &&
    !reload_reg && !blocked_reg && !fieldbus_frame_i && timeout_cnt_reg == '0
    |=> state_reg == rt_node_pkg::ST_FIRST_PREOP_PHASE)
    else $error("Master did not start after bus timeout.");

  master_block_a: assert property ( // RQ2
    clk_en_i && state_reg == rt_node_pkg::ST_INACTIVE && role_reg && node_enable_i &&
    !reload_reg && fieldbus_frame_i |=> state_reg == rt_node_pkg::ST_INACTIVE && blocked_reg [*2])
    else $error("Master started despite fieldbus traffic.");

  slave_timeout_a: assert property ( // RQ3
    clk_en_i && state_reg == rt_node_pkg::ST_INACTIVE && !role_reg && node_enable_i &&
    !reload_reg && !fieldbus_frame_i && timeout_cnt_reg == '0
    |=> state_reg == rt_node_pkg::ST_PLAIN_TCPIP_FALLBACK ##0 tcpip_mode_o)
    else $error("Slave did not fall back after timeout.");

  slave_detect_a: assert property ( // RQ3
    clk_en_i && state_reg == rt_node_pkg::ST_INACTIVE && !role_reg && node_enable_i &&
    !reload_reg && fieldbus_frame_i |=> state_reg == rt_node_pkg::ST_FIRST_PREOP_PHASE)
    else $error("Slave missed fieldbus traffic while inactive.");

  master_fallback_hold_a: assert property ( // RQ5
    role_reg && state_reg == rt_node_pkg::ST_PLAIN_TCPIP_FALLBACK
    |=> state_reg == rt_node_pkg::ST_PLAIN_TCPIP_FALLBACK)
    else $error("Master left fallback without reset.");

  slave_fallback_exit_a: assert property ( // RQ6
    clk_en_i && !role_reg && node_enable_i && fieldbus_frame_i &&
    state_reg == rt_node_pkg::ST_PLAIN_TCPIP_FALLBACK |=> state_reg == rt_node_pkg::ST_FIRST_PREOP_PHASE)
    else $error("Slave stayed in fallback despite traffic.");

  soc_advance_a: assert property ( // RQ9
    clk_en_i && !role_reg && node_enable_i && soc_frame_i &&
    state_reg == rt_node_pkg::ST_FIRST_PREOP_PHASE |=> state_reg == rt_node_pkg::ST_SECOND_PREOP_PHASE)
    else $error("Start-of-cycle frame did not advance the slave.");

  red_fail_a: assert property ( // RQ10
    clk_en_i && !role_reg && master_fail_i &&
    state_reg inside {rt_node_pkg::ST_FIRST_PREOP_PHASE, rt_node_pkg::ST_SECOND_PREOP_PHASE,
                      rt_node_pkg::ST_ARMED_STATE} |=> led_red_o)
    else $error("Red LED dark after master failure.");

  oper_green_a: assert property ( // RQ17
    clk_en_i && state_reg == rt_node_pkg::ST_OPERATIONAL ##1 clk_en_i && $stable(state_reg)
    |-> led_green_o && eval_rx_pdo_o)
    else $error("Operational without steady green or evaluation.");

  no_master_stop_a: assert property ( // RQ19
    role_reg |-> state_reg != rt_node_pkg::ST_STOPPED)
    else $error("Master reached the stopped state.");

  stop_silence_a: assert property ( // RQ20
    state_reg == rt_node_pkg::ST_STOPPED |-> !drive_outputs_o && !provide_inputs_o && !tx_pdo_o)
    else $error("Data moved while stopped.");

  // Main scenarios worth seeing in simulation.
  cover_fallback_c: cover property (state_reg == rt_node_pkg::ST_PLAIN_TCPIP_FALLBACK);
  cover_operational_c: cover property (state_reg == rt_node_pkg::ST_OPERATIONAL);
  cover_stopped_c: cover property (state_reg == rt_node_pkg::ST_STOPPED ##1
                                   state_reg == rt_node_pkg::ST_SECOND_PREOP_PHASE);
  cover_blocked_c: cover property ($rose(blocked_reg));

endmodule

`default_nettype wire

// File: rt_node_pkg.sv
`default_nettype none

package rt_node_pkg;

  // Node states, one-hot so that an upset code is caught by the default branch.
  typedef enum logic [6:0] {
    ST_INACTIVE             = 7'h01,
    ST_PLAIN_TCPIP_FALLBACK = 7'h02,
    ST_FIRST_PREOP_PHASE    = 7'h04,
    ST_SECOND_PREOP_PHASE   = 7'h08,
    ST_ARMED_STATE          = 7'h10,
    ST_OPERATIONAL          = 7'h20,
    ST_STOPPED              = 7'h40
  } node_state_t;

  // System clock rate.
  localparam int unsigned CLK_FREQ_HZ     = 125_000_000;

  // Indicator rates, each in its own unit as printed.
  localparam int unsigned FLICKER_FREQ_HZ = 10;
  localparam int unsigned FLASH_FREQ_HZ   = 1;
  localparam int unsigned BLINK_FREQ_DHZ  = 25;

  // One tick is half a flicker period; every pattern is built from ticks.
  localparam int unsigned TICK_CYCLES     = CLK_FREQ_HZ / (2 * FLICKER_FREQ_HZ);
  localparam int unsigned TICKS_PER_FLASH = (2 * FLICKER_FREQ_HZ) / FLASH_FREQ_HZ;
  localparam int unsigned TICKS_PER_BLINK = (2 * FLICKER_FREQ_HZ * 10) / (2 * BLINK_FREQ_DHZ);
  localparam int unsigned FLASH_ON_TICKS  = 2;

  // Counter widths and reset values.
  localparam int unsigned TICK_CNT_W      = 23;
  localparam int unsigned PHASE_W         = 5;
  localparam int unsigned BLINK_W         = 3;
  localparam int unsigned TIMEOUT_W       = 32;
  localparam logic [TIMEOUT_W-1:0] TIMEOUT_RESET = 32'h0000_0000;

endpackage

`default_nettype wire

// File: status_led_encoder.sv
`timescale 1ns/100ps
`default_nettype none

module status_led_encoder #(
  parameter int unsigned TICK_CYCLES = rt_node_pkg::TICK_CYCLES
) (
  input  wire logic                     mclk_i,
  input  wire logic                     reset_n_i,
  input  wire logic                     clk_en_i,
  input  wire rt_node_pkg::node_state_t state_i,
  output var  logic                     led_o
);

  logic [rt_node_pkg::TICK_CNT_W-1:0] tick_cnt_reg;
  logic [rt_node_pkg::TICK_CNT_W-1:0] tick_cnt_next;
  logic [rt_node_pkg::PHASE_W-1:0]    phase_reg;
  logic [rt_node_pkg::PHASE_W-1:0]    phase_next;
  logic [rt_node_pkg::BLINK_W-1:0]    blink_cnt_reg;
  logic [rt_node_pkg::BLINK_W-1:0]    blink_cnt_next;
  logic                               flicker_reg;
  logic                               flicker_next;
  logic                               blink_reg;
  logic                               blink_next;
  logic                               led_next;
  logic                               tick;

  // Lit while the phase falls in one of the first count on-pulses of the period.
  function automatic logic flash_lit(input logic [rt_node_pkg::PHASE_W-1:0] phase, input int unsigned count);
    int unsigned p;
    p = int'(phase);
    flash_lit = ((p / rt_node_pkg::FLASH_ON_TICKS) % 2 == 0) &&
                (p < (2 * count - 1) * rt_node_pkg::FLASH_ON_TICKS);
  endfunction

  assign tick = (tick_cnt_reg == rt_node_pkg::TICK_CNT_W'(TICK_CYCLES - 1));

  // One free-running period counter feeds every pattern, so all flashes share period and width.
  always_comb begin
    tick_cnt_next  = tick ? '0 : tick_cnt_reg + 1'b1; // RQ21
    phase_next     = phase_reg;
    blink_cnt_next = blink_cnt_reg;
    flicker_next   = flicker_reg;
    blink_next     = blink_reg;
    if (tick) begin
      flicker_next = ~flicker_reg; // RQ4
      phase_next   = (phase_reg == rt_node_pkg::PHASE_W'(rt_node_pkg::TICKS_PER_FLASH - 1)) ?
                     '0 : phase_reg + 1'b1; // RQ21
      if (blink_cnt_reg == rt_node_pkg::BLINK_W'(rt_node_pkg::TICKS_PER_BLINK - 1)) begin
        blink_cnt_next = '0;
        blink_next     = ~blink_reg; // RQ18
      end else begin
        blink_cnt_next = blink_cnt_reg + 1'b1;
      end
    end
    unique case (state_i)
      rt_node_pkg::ST_INACTIVE:             led_next = 1'b0; // RQ1
      rt_node_pkg::ST_PLAIN_TCPIP_FALLBACK: led_next = flicker_reg; // RQ4
      rt_node_pkg::ST_FIRST_PREOP_PHASE:    led_next = flash_lit(phase_reg, 1); // RQ7
      rt_node_pkg::ST_SECOND_PREOP_PHASE:   led_next = flash_lit(phase_reg, 2); // RQ11
      rt_node_pkg::ST_ARMED_STATE:          led_next = flash_lit(phase_reg, 3); // RQ14
      rt_node_pkg::ST_OPERATIONAL:          led_next = 1'b1; // RQ17
      rt_node_pkg::ST_STOPPED:              led_next = blink_reg; // RQ18
      default:                              led_next = 1'b0;
    endcase
  end

  // Registers only; the enable freezes the whole pattern generator.
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      tick_cnt_reg  <= '0;
      phase_reg     <= '0;
      blink_cnt_reg <= '0;
      flicker_reg   <= 1'b0;
      blink_reg     <= 1'b0;
      led_o         <= 1'b0;
    end else if (clk_en_i) begin
      tick_cnt_reg  <= tick_cnt_next;
      phase_reg     <= phase_next;
      blink_cnt_reg <= blink_cnt_next;
      flicker_reg   <= flicker_next;
      blink_reg     <= blink_next;
      led_o         <= led_next;
    end
  end

endmodule

`default_nettype wire

// File: peer_node_model.sv
`timescale 1ns/100ps
`default_nettype none

// Another node on the segment. The bench picks a message code just after an edge
// and holds it for one cycle, so each message reaches the node as a single event.
module peer_node_model (
  input  wire logic [2:0] op_i,
  output var  logic       frame_o,
  output var  logic       soc_o,
  output var  logic       ready_o,
  output var  logic       operate_o,
  output var  logic       stop_o,
  output var  logic       leave_o
);
  // Code 0 keeps the segment quiet; the commands only come from a managing peer.
  always_comb begin
    frame_o   = (op_i == 3'h1);
    soc_o     = (op_i == 3'h2);
    ready_o   = (op_i == 3'h3);
    operate_o = (op_i == 3'h4);
    stop_o    = (op_i == 3'h5);
    leave_o   = (op_i == 3'h6);
  end
endmodule

`default_nettype wire

// File: rt_ethernet_node_state_led_test.sv
`timescale 1ns/100ps
`default_nettype none

module rt_ethernet_node_state_led_test;
  localparam int TICKS = 4;
  logic        mclk_i    = 1'b0;
  logic        reset_n_i = 1'b0;
  logic        clk_en_i  = 1'b1;
  logic        role_i    = 1'b0;
  logic        en_i      = 1'b1;
  logic        fail_i    = 1'b0;
  logic        adv_i     = 1'b0;
  logic [2:0]  op        = 3'h0;
  logic [31:0] tout      = 32'h0000_0002;
  logic        frame, soc, rdy, opr, stp, lvs;
  logic        green, red, rmo, blk, tcp, rcyc, cyc, asy, acc, txp, evp, drv, prv;
  rt_node_pkg::node_state_t st;
  int          err_count   = 0;
  int          checks_done = 0;
  int          cycles      = 0;

  // The short tick keeps a full flash period at 80 cycles.
  rt_ethernet_node_state_led #(.TICK_CYCLES(TICKS)) i_rt_ethernet_node_state_led (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i), .role_master_i(role_i),
    .node_enable_i(en_i), .fieldbus_frame_i(frame), .soc_frame_i(soc), .master_fail_i(fail_i),
    .advance_i(adv_i), .cmd_ready_i(rdy), .cmd_operate_i(opr), .cmd_stop_i(stp),
    .cmd_leave_stop_i(lvs), .timeout_cycles_i(tout), .led_green_o(green), .led_red_o(red),
    .state_o(st), .role_master_o(rmo), .master_blocked_o(blk), .tcpip_mode_o(tcp),
    .reduced_cycle_o(rcyc), .cyclic_comm_o(cyc), .async_comm_o(asy), .accept_config_o(acc),
    .tx_pdo_o(txp), .eval_rx_pdo_o(evp), .drive_outputs_o(drv), .provide_inputs_o(prv));

  peer_node_model i_peer_node_model (
    .op_i(op), .frame_o(frame), .soc_o(soc), .ready_o(rdy), .operate_o(opr),
    .stop_o(stp), .leave_o(lvs));

  // Clock and a hang guard well beyond the roughly 700 cycles the run needs.
  always #4 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (err_count == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Every drive happens 1 ns after an edge, away from the sampling instant.
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic restart(input logic master, input logic [31:0] t);
    reset_n_i = 1'b0;
    role_i = master;
    tout = t;
    tick(5);
    reset_n_i = 1'b1;
  endtask

  task automatic send(input logic [2:0] code);
    op = code;
    tick(1);
    op = 3'h0;
  endtask

  task automatic step();
    adv_i = 1'b1;
    tick(1);
    adv_i = 1'b0;
  endtask

  // Windows span whole periods of the free-running counter, so the phase does not matter.
  task automatic lit(input string name, input int n, input int exp);
    int c;
    c = 0;
    repeat (n) begin
      tick(1);
      c += int'(green === 1'b1);
    end
    chk(name, exp, c);
  endtask

  task automatic slave_walk();
    restart(1'b0, 32'h0000_0002);
    chk("led_green_o", 0, green);
    tick(3);
    chk("state_o", rt_node_pkg::ST_INACTIVE, st);
    tick(1);
    chk("state_o", rt_node_pkg::ST_PLAIN_TCPIP_FALLBACK, st);
    chk("tcpip_mode_o", 1, tcp);
    chk("role_master_o", 0, rmo);
    tick(2);
    lit("flicker", 80, 40);
    send(3'h1);
    chk("state_o", rt_node_pkg::ST_FIRST_PREOP_PHASE, st);
    chk("accept_config_o", 1, acc);
    tick(2);
    lit("single flash", 80, 8);
    clk_en_i = 1'b0;
    send(3'h2);
    clk_en_i = 1'b1;
    step();
    chk("state_o", rt_node_pkg::ST_FIRST_PREOP_PHASE, st);
    fail_i = 1'b1;
    tick(1);
    chk("led_red_o", 1, red);
    fail_i = 1'b0;
    send(3'h2);
    chk("state_o", rt_node_pkg::ST_SECOND_PREOP_PHASE, st);
    chk("led_red_o", 0, red);
    tick(2);
    lit("double flash", 80, 16);
    send(3'h3);
    chk("state_o", rt_node_pkg::ST_ARMED_STATE, st);
    chk("tx_pdo_o", 1, txp);
    chk("eval_rx_pdo_o", 0, evp);
    tick(2);
    lit("triple flash", 80, 24);
    send(3'h4);
    chk("drive_outputs_o", 1, drv);
    chk("eval_rx_pdo_o", 1, evp);
    lit("steady", 80, 80);
    send(3'h5);
    chk("state_o", rt_node_pkg::ST_STOPPED, st);
    chk("provide_inputs_o", 0, prv);
    tick(2);
    lit("blink", 160, 80);
    send(3'h6);
    chk("state_o", rt_node_pkg::ST_SECOND_PREOP_PHASE, st);
    en_i = 1'b0;
    tick(2);
    chk("led_green_o", 0, green);
    en_i = 1'b1;
  endtask

  task automatic master_walk();
    restart(1'b1, 32'h0000_0003);
    tick(6);
    chk("state_o", rt_node_pkg::ST_FIRST_PREOP_PHASE, st);
    chk("reduced_cycle_o", 1, rcyc);
    chk("role_master_o", 1, rmo);
    chk("cyclic_comm_o", 0, cyc);
    step();
    chk("cyclic_comm_o", 1, cyc);
    chk("eval_rx_pdo_o", 0, evp);
    send(3'h5);
    chk("state_o", rt_node_pkg::ST_SECOND_PREOP_PHASE, st);
    step();
    chk("async_comm_o", 1, asy);
    chk("eval_rx_pdo_o", 0, evp);
    send(3'h5);
    chk("state_o", rt_node_pkg::ST_ARMED_STATE, st);
  endtask

  // The role turns to master on the very edge the slave times out, leaving a master in fallback.
  task automatic master_fallback();
    restart(1'b0, 32'h0000_0002);
    tick(3);
    role_i = 1'b1;
    tick(1);
    chk("state_o", rt_node_pkg::ST_PLAIN_TCPIP_FALLBACK, st);
    chk("role_master_o", 1, rmo);
    en_i = 1'b0;
    send(3'h1);
    tick(2);
    chk("state_o", rt_node_pkg::ST_PLAIN_TCPIP_FALLBACK, st);
    chk("tcpip_mode_o", 1, tcp);
    en_i = 1'b1;
  endtask

  task automatic traffic_first();
    restart(1'b0, 32'h0000_0064);
    tick(3);
    send(3'h1);
    chk("state_o", rt_node_pkg::ST_FIRST_PREOP_PHASE, st);
    restart(1'b1, 32'h0000_0032);
    tick(3);
    send(3'h1);
    chk("master_blocked_o", 1, blk);
    tick(60);
    chk("state_o", rt_node_pkg::ST_INACTIVE, st);
  endtask

  // Reset is held for the first five cycles inside each restart.
  initial begin
    slave_walk();
    master_walk();
    master_fallback();
    traffic_first();
    report_and_stop();
  end
endmodule

`default_nettype wire
